// >>> irq_time_multiplexer_test.sv
`timescale 1ns/100ps
`default_nettype none

module irq_time_multiplexer_test;
    import itmx_pkg::*;
    // ------------------------------------------------------------
    // wiring
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    itmx_irq_in_t lines = 16'hFFFE;
    itmx_port_t prt = '0;
    itmx_bus_t bus = 14'h3800;
    logic [2:0] base = 3'h0;
    logic tog = 1'b0;
    logic slow = 1'b0;
    wire logic [2:0] sel;
    logic [7:0] data;
    logic data_oe_n, out_a, oe_a_n, out_b, oe_b_n, irq7, irq7_oe_n;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int lane_of [1:9] = '{11, 12, 13, 14, 15, 2, 3, 4, 7};
    itmx_ctrl_model ctrl (.sys_clk_i(sys_clk), .nrst_i(nrst), .base_i(base), .tog_i(tog),
        .slow_i(slow), .sel_o(sel));
    itmx_top uut (.sys_clk_i(sys_clk), .nrst_i(nrst), .irq_mux_select_i(sel),
        .irq_lines_i(lines), .ports_i(prt), .bus_i(bus), .data_o(data),
        .data_oe_n_o(data_oe_n), .mux_out_a_o(out_a), .mux_out_a_oe_n_o(oe_a_n),
        .mux_out_b_o(out_b), .mux_out_b_oe_n_o(oe_b_n), .irq7_o(irq7), .irq7_oe_n_o(irq7_oe_n));
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // iow_n goes back high between writes so each one is taken
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        tick(1);
        bus.cs2_n = 1'b0;
        bus.addr = a;
        bus.wdata = d;
        bus.iow_n = 1'b0;
        tick(1);
        bus.iow_n = 1'b1;
        bus.cs2_n = 1'b1;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        tick(1);
        bus.cs2_n = 1'b0;
        bus.addr = a;
        bus.ior_n = 1'b0;
        tick(2);
        chk({7'h0, data_oe_n}, 8'h00);
        chk(data, exp);
        bus.ior_n = 1'b1;
        bus.cs2_n = 1'b1;
    endtask
    task automatic show(input int l, output logic v);
        tog = 1'b0;
        base = l[2:0];
        tick(2);
        v = (l > 7) ? out_b : out_a;
    endtask
    task automatic peek(input logic [2:0] s, output logic va);
        int n;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (sel !== s && n < 8);
        tick(1);
        va = out_a;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        for (int i = 2; i < 5; i++)
        begin
            wr(ADDR_SEL_PORT, 8'(i));
            rd(DATA_ACC_PORT, 8'h00);
        end
        wr(ADDR_SEL_PORT, {5'h0, IDX_UART1_ROUTE});
        wr(DATA_ACC_PORT, 8'h05);
        rd(DATA_ACC_PORT, 8'h05);
        wr(DATA_ACC_PORT, 8'h00);
        wr(ADDR_SEL_PORT, 8'h05);
        wr(DATA_ACC_PORT, 8'h03);
        rd(DATA_ACC_PORT, 8'h00);
        rd(ADDR_SEL_PORT, 8'h05);
    endtask
    task automatic t_lanes;
        logic v;
        lines = 16'h5A3C;
        for (int l = 0; l < 16; l++)
        begin
            show(l, v);
            chk({7'h0, v}, {7'h0, lines[l]});
        end
        lines = 16'hFFFE;
        tog = 1'b1;
        tick(40);
    endtask
    // stretch timing is counted in select bit 0 edges, not clocks
    task automatic t_stretch;
        logic va;
        base = 3'h0;
        lines.irq9 = 1'b0;
        tick(1);
        lines.irq9 = 1'b1;
        peek(3'h1, va);
        chk({7'h0, va}, 8'h00);
        tick(16);
        peek(3'h1, va);
        chk({7'h0, va}, 8'h01);
        lines.irq9 = 1'b0;
        tick(20);
        lines.irq9 = 1'b1;
        tick(1);
        lines.irq9 = 1'b0;
        repeat (3)
        begin
            peek(3'h1, va);
            chk({7'h0, va}, 8'h00);
        end
        lines.irq9 = 1'b1;
        peek(3'h1, va);
        chk({7'h0, va}, 8'h00);
        tick(12);
        peek(3'h1, va);
        chk({7'h0, va}, 8'h01);
        lines.irq8 = 1'b1;
        tick(1);
        lines.irq8 = 1'b0;
        peek(3'h0, va);
        chk({7'h0, va}, 8'h01);
        tick(16);
        peek(3'h0, va);
        chk({7'h0, va}, 8'h00);
        slow = 1'b1;
        lines.irq9 = 1'b0;
        tick(1);
        lines.irq9 = 1'b1;
        tick(6);
        peek(3'h1, va);
        chk({7'h0, va}, 8'h00);
        tick(30);
        peek(3'h1, va);
        chk({7'h0, va}, 8'h01);
        slow = 1'b0;
    endtask
    task automatic t_route;
        logic v;
        for (int c = 1; c < 10; c++)
        begin
            wr(ADDR_SEL_PORT, {5'h0, IDX_UART0_ROUTE});
            wr(DATA_ACC_PORT, 8'(c));
            prt.uart0_mcr = 8'h08;
            show(lane_of[c], v);
            chk({7'h0, v}, 8'h00);
            prt.uart0_mcr = 8'h18;
            show(lane_of[c], v);
            chk({7'h0, v}, 8'h01);
        end
        prt.uart0_mcr = 8'h08;
        prt.uart1_mcr = 8'h08;
        prt.uart1_irq = 1'b1;
        wr(ADDR_SEL_PORT, {5'h0, IDX_UART1_ROUTE});
        wr(DATA_ACC_PORT, 8'h09);
        show(7, v);
        chk({7'h0, v}, 8'h01);
        wr(ADDR_SEL_PORT, {5'h0, IDX_PRINTER_ROUTE});
        wr(DATA_ACC_PORT, 8'h09);
        show(7, v);
        chk({7'h0, v}, 8'h01);
        prt.printer_wcr = 8'h10;
        show(7, v);
        chk({7'h0, v}, 8'h00);
        prt.paper_end = 1'b1;
        wr(ADDR_SEL_PORT, {5'h10, IDX_PRINTER_ROUTE});
        show(7, v);
        chk({7'h0, v}, 8'h01);
    endtask
    task automatic t_solo;
        wr(ADDR_SEL_PORT, {5'h0, IDX_UART0_ROUTE});
        wr(DATA_ACC_PORT, {4'h0, ROUTE_STANDALONE});
        prt.uart0_irq = 1'b1;
        prt.uart1_irq = 1'b0;
        prt.printer_irq = 1'b1;
        prt.uart1_mcr = 8'h00;
        tick(3);
        chk({2'h0, out_a, oe_a_n, out_b, oe_b_n, irq7, irq7_oe_n}, 8'h26);
        wr(DATA_ACC_PORT, 8'h00);
        tick(3);
        chk({6'h0, oe_a_n, irq7_oe_n}, 8'h01);
    endtask
    initial
    begin
        tick(6);
        nrst = 1'b1;
        t_regs;
        t_lanes;
        t_stretch;
        t_route;
        t_solo;
        end_of_test;
    end
    // hang guard, well above the few hundred cycles needed
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test;
        end
    end
endmodule

`default_nettype wire

// >>> itmx_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none

module itmx_ctrl_model
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // command from bench
    input wire logic [2:0] base_i,
    input wire logic tog_i,
    input wire logic slow_i,
    // select code to device
    output logic [2:0] sel_o
);
    logic [1:0] ph_q;
    // select code, bit 0 toggled to time the stretch
    // slow mode halves the edge rate, as a lazy controller would
    assign sel_o = tog_i ? {base_i[2:1], base_i[0] ^ ph_q[slow_i]} : base_i;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            ph_q <= 2'h0;
        else
            ph_q <= ph_q + 2'h1;
    end
endmodule

`default_nettype wire

// >>> itmx_pkg.sv
package itmx_pkg;

    // ------------------------------------------------------------
    // register addressing
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_SEL_PORT = 3'h3;
    localparam logic [2:0] DATA_ACC_PORT = 3'h4;
    localparam logic [2:0] IDX_UART0_ROUTE = 3'h2;
    localparam logic [2:0] IDX_UART1_ROUTE = 3'h3;
    localparam logic [2:0] IDX_PRINTER_ROUTE = 3'h4;
    localparam logic [7:0] ADDR_SEL_RESET = 8'h00;
    localparam logic [3:0] ROUTE_RESET = 4'h0;
    localparam int TEST_BIT = 7;

    // ------------------------------------------------------------
    // routing codes and enables
    // ------------------------------------------------------------
    localparam logic [3:0] ROUTE_OFF = 4'h0;
    localparam logic [3:0] ROUTE_STANDALONE = 4'hF;
    localparam int MCR_LOOP_BIT = 4;
    localparam int MCR_OUT2_BIT = 3;
    localparam int WCR_IRQ_EN_BIT = 4;

    // ------------------------------------------------------------
    // pulse stretch timing, in select bit 0 rising edges
    // ------------------------------------------------------------
    localparam logic [2:0] LEAD_EDGES = 3'h5;
    localparam logic [1:0] TRAIL_EDGES = 2'h3;

    // mux input index = {output b, select code}
    localparam logic [15:0] STRETCH_EN = 16'hFBCF;
    localparam logic [15:0] STRETCH_HIGH = 16'h0001;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic irq7;
        logic irq6;
        logic irq5;
        logic irq4;
        logic irq3;
        logic gate_a20_in;
        logic keyboard_irq_in;
        logic irq12;
        logic irq15;
        logic irq14;
        logic cpu_reset_request;
        logic rom_size_in;
        logic irq11;
        logic irq10;
        logic irq9;
        logic irq8;
    } itmx_irq_in_t;

    typedef struct packed {
        logic cs2_n;
        logic ior_n;
        logic iow_n;
        logic [2:0] addr;
        logic [7:0] wdata;
    } itmx_bus_t;

    typedef struct packed {
        logic uart0_irq;
        logic uart1_irq;
        logic printer_irq;
        logic [7:0] uart0_mcr;
        logic [7:0] uart1_mcr;
        logic [7:0] printer_wcr;
        logic printer_select;
        logic printer_busy;
        logic paper_end;
    } itmx_port_t;

endpackage

// >>> itmx_stretch.sv
`timescale 1ns/100ps
`default_nettype none

module itmx_stretch
#(
    parameter bit ACT_HIGH = 1'b0
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // select bit 0 rising edge and raw line
    input wire logic edge_i,
    input wire logic raw_i,
    // widened line, same polarity as raw
    output logic out_o
);
    import itmx_pkg::*;

    logic active;
    logic rise;
    logic stretched;
    logic act_prev_q;
    logic [2:0] lead_q;
    logic [2:0] lead_d;
    logic [1:0] trail_q;
    logic [1:0] trail_d;

    assign active = ACT_HIGH ? raw_i : ~raw_i;
    assign rise = active & ~act_prev_q;

    // ------------------------------------------------------------
    // edge counters
    // ------------------------------------------------------------
    // [R6] lead count
    assign lead_d = rise ? 3'h0 :
        ((edge_i && lead_q < LEAD_EDGES) ? lead_q + 3'h1 : lead_q);
    // [R7] gaps under three edges hidden
    assign trail_d = active ? 2'h0 :
        ((edge_i && trail_q < TRAIL_EDGES) ? trail_q + 2'h1 : trail_q);

    // [R6] later of both windows
    assign stretched = active | (lead_q < LEAD_EDGES) | (trail_q < TRAIL_EDGES);
    assign out_o = ACT_HIGH ? stretched : ~stretched;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            act_prev_q <= 1'b0;
            lead_q <= LEAD_EDGES;
            trail_q <= TRAIL_EDGES;
        end
        else
        begin
            act_prev_q <= active;
            lead_q <= lead_d;
            trail_q <= trail_d;
        end
    end

endmodule

`default_nettype wire

// >>> itmx_top.sv
// Notes on behaviour
// [R1] controller drives 3-bit select; it picks what both mux outputs show
// [R2] output a order: irq8, irq9, irq10, irq11, rom size, cpu reset, irq14, irq15
// [R3] output b order: irq12, keyboard, gate a20, irq3, irq4, irq5, irq6, irq7
// [R4] low pulses widened on irq3-7, irq9-12, irq14, irq15, keyboard
// [R5] high pulses widened on irq8 with same timing
// [R6] widened until five select edges after lead or three after trail
// [R7] opposite pulses spanning under three select edges never show
// [R8] cpu reset, rom size and gate a20 pass unwidened
// [R9] uart0 route code 1111 selects stand-alone mode, mux logic off
// [R10] stand-alone: outputs carry uart0 and uart1 irqs, enabled by modem control
// [R11] stand-alone: irq7 pin carries printer irq, enabled by write control bit 4
// [R12] uart0 route code replaces one chosen mux input with uart0 irq
// [R13] serial route acts only with modem control bit 4 low, bit 3 high
// [R14] uart1 route uses same codes, without stand-alone code
// [R15] printer route uses same codes, active only with write control bit 4
// [R16] uart1 wins over uart0 on same input, no or-ing
// [R17] printer wins over both serial routes on same input, no or-ing
// [R18] software writes zero into route register bits 7-4
// [R19] route registers reached through index register then data port
// [R20] indices 2, 3, 4 pick uart0, uart1, printer route; reset 00h
// [R21] index register at chip select 2, address 3, read or write strobe
// [R22] test bit swaps uart1, uart0, printer irqs for select, busy, paper end
// [R23] outputs follow select with no pipeline beyond the output flop
`timescale 1ns/100ps
`default_nettype none

module itmx_top
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // select code from system controller
    input wire logic [2:0] irq_mux_select_i,
    // interrupt request lines and system signals
    input wire itmx_pkg::itmx_irq_in_t irq_lines_i,
    // internal port interrupts and their enables
    input wire itmx_pkg::itmx_port_t ports_i,
    // host register access
    input wire itmx_pkg::itmx_bus_t bus_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    // multiplexed outputs
    output logic mux_out_a_o,
    output logic mux_out_a_oe_n_o,
    output logic mux_out_b_o,
    output logic mux_out_b_oe_n_o,
    // irq7 pin drive in stand-alone mode
    output logic irq7_o,
    output logic irq7_oe_n_o
);
    import itmx_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] addr_sel_q;
    logic [3:0] uart0_irq_route_q;
    logic [3:0] uart1_irq_route_q;
    logic [3:0] printer_irq_route_q;
    logic iow_prev_q;
    logic sel0_prev_q;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic data_oe_n_q;
    logic data_oe_n_d;
    logic out_a_q;
    logic out_a_d;
    logic out_a_oe_n_q;
    logic out_a_oe_n_d;
    logic out_b_q;
    logic out_b_d;
    logic out_b_oe_n_q;
    logic out_b_oe_n_d;
    logic irq7_q;
    logic irq7_d;
    logic irq7_oe_n_q;
    logic irq7_oe_n_d;

    logic sel_edge;
    logic [15:0] mux_raw;
    logic [15:0] mux_wide;
    logic [15:0] mux_final;
    logic [15:0] uart0_hit;
    logic [15:0] uart1_hit;
    logic [15:0] printer_hit;
    logic [4:0] uart0_idx;
    logic [4:0] uart1_idx;
    logic [4:0] printer_idx;
    logic uart0_en;
    logic uart1_en;
    logic printer_en;
    logic standalone;
    logic test_mode;
    logic uart0_sig;
    logic uart1_sig;
    logic printer_sig;

    logic cs_active;
    logic at_addr_sel;
    logic at_data_acc;
    logic wr_strobe;
    logic wr_addr_sel;
    logic wr_uart0;
    logic wr_uart1;
    logic wr_printer;
    logic rd_active;
    logic [2:0] acc_idx;
    logic [7:0] acc_rdata;

    // ------------------------------------------------------------
    // route code to mux input index, msb marks a live code
    // ------------------------------------------------------------
    // [R12] route code table
    function automatic logic [4:0] route_index(input logic [3:0] code);
        logic [4:0] idx;
        idx = 5'h00;
        unique case (code)
            4'h1: idx = 5'h1B;
            4'h2: idx = 5'h1C;
            4'h3: idx = 5'h1D;
            4'h4: idx = 5'h1E;
            4'h5: idx = 5'h1F;
            4'h6: idx = 5'h12;
            4'h7: idx = 5'h13;
            4'h8: idx = 5'h14;
            4'h9: idx = 5'h17;
            default: idx = 5'h00;
        endcase
        return idx;
    endfunction

    // ------------------------------------------------------------
    // register access decode
    // ------------------------------------------------------------
    // [R21] chip select 2 with address 3
    assign cs_active = ~bus_i.cs2_n;
    assign at_addr_sel = cs_active & (bus_i.addr == ADDR_SEL_PORT);
    assign at_data_acc = cs_active & (bus_i.addr == DATA_ACC_PORT);
    // one write per falling edge of the write strobe
    assign wr_strobe = ~bus_i.iow_n & iow_prev_q & bus_i.ior_n;
    assign wr_addr_sel = wr_strobe & at_addr_sel;
    // [R19] data port goes through the index
    assign acc_idx = addr_sel_q[2:0];
    // [R20] index decode
    assign wr_uart0 = wr_strobe & at_data_acc & (acc_idx == IDX_UART0_ROUTE);
    assign wr_uart1 = wr_strobe & at_data_acc & (acc_idx == IDX_UART1_ROUTE);
    assign wr_printer = wr_strobe & at_data_acc & (acc_idx == IDX_PRINTER_ROUTE);
    assign rd_active = ~bus_i.ior_n & bus_i.iow_n & (at_addr_sel | at_data_acc);

    // other indices belong to other blocks and read zero here
    assign acc_rdata = (acc_idx == IDX_UART0_ROUTE) ? {4'h0, uart0_irq_route_q} :
        (acc_idx == IDX_UART1_ROUTE) ? {4'h0, uart1_irq_route_q} :
        (acc_idx == IDX_PRINTER_ROUTE) ? {4'h0, printer_irq_route_q} : 8'h00;
    assign data_d = at_addr_sel ? addr_sel_q : acc_rdata;
    assign data_oe_n_d = ~rd_active;

    // ------------------------------------------------------------
    // pulse widening per mux input
    // ------------------------------------------------------------
    assign sel_edge = irq_mux_select_i[0] & ~sel0_prev_q;
    assign mux_raw = irq_lines_i;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_lane
            if (STRETCH_EN[gi])
            begin : g_wide
                // [R4] [R5] widen by polarity
                itmx_stretch #(
                    .ACT_HIGH(STRETCH_HIGH[gi])
                ) u_stretch (
                    .sys_clk_i(sys_clk_i),
                    .nrst_i(nrst_i),
                    .edge_i(sel_edge),
                    .raw_i(mux_raw[gi]),
                    .out_o(mux_wide[gi])
                );
            end
            else
            begin : g_pass
                // [R8] no widening
                assign mux_wide[gi] = mux_raw[gi];
            end
            // [R16] [R17] printer over uart1 over uart0
            assign uart0_hit[gi] = uart0_en & uart0_idx[4] & (uart0_idx[3:0] == gi);
            assign uart1_hit[gi] = uart1_en & uart1_idx[4] & (uart1_idx[3:0] == gi);
            assign printer_hit[gi] = printer_en & printer_idx[4] & (printer_idx[3:0] == gi);
            assign mux_final[gi] = printer_hit[gi] ? printer_sig :
                uart1_hit[gi] ? uart1_sig :
                uart0_hit[gi] ? uart0_sig : mux_wide[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // substitution sources and enables
    // ------------------------------------------------------------
    // [R22] test bit swaps sources
    assign test_mode = addr_sel_q[TEST_BIT];
    assign uart1_sig = test_mode ? ports_i.printer_select : ports_i.uart1_irq;
    assign uart0_sig = test_mode ? ports_i.printer_busy : ports_i.uart0_irq;
    assign printer_sig = test_mode ? ports_i.paper_end : ports_i.printer_irq;

    // [R13] modem control gating
    assign uart0_en = ~ports_i.uart0_mcr[MCR_LOOP_BIT] & ports_i.uart0_mcr[MCR_OUT2_BIT];
    assign uart1_en = ~ports_i.uart1_mcr[MCR_LOOP_BIT] & ports_i.uart1_mcr[MCR_OUT2_BIT];
    // [R15] write control gating
    assign printer_en = ports_i.printer_wcr[WCR_IRQ_EN_BIT];

    // [R12] [R14] decode codes
    assign uart0_idx = route_index(uart0_irq_route_q);
    assign uart1_idx = route_index(uart1_irq_route_q);
    assign printer_idx = route_index(printer_irq_route_q);

    // [R9] stand-alone code on uart0 route
    assign standalone = (uart0_irq_route_q == ROUTE_STANDALONE);

    // ------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------
    // [R1] [R2] [R3] select picks lane; [R23] only output flop delay
    assign out_a_d = standalone ? uart0_sig : mux_final[{1'b0, irq_mux_select_i}];
    assign out_b_d = standalone ? uart1_sig : mux_final[{1'b1, irq_mux_select_i}];
    // [R10] drive enabled by modem control
    assign out_a_oe_n_d = standalone ? ~ports_i.uart0_mcr[MCR_OUT2_BIT] : 1'b0;
    assign out_b_oe_n_d = standalone ? ~ports_i.uart1_mcr[MCR_OUT2_BIT] : 1'b0;
    // [R11] irq7 pin carries printer irq
    assign irq7_d = printer_sig;
    assign irq7_oe_n_d = ~(standalone & ports_i.printer_wcr[WCR_IRQ_EN_BIT]);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            addr_sel_q <= ADDR_SEL_RESET;
            iow_prev_q <= 1'b1;
        end
        else
        begin
            iow_prev_q <= bus_i.iow_n;
            // [R21] index register write
            if (wr_addr_sel)
            begin
                addr_sel_q <= bus_i.wdata;
            end
        end
    end

    // upper bits are not stored; they read as zero
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            uart0_irq_route_q <= ROUTE_RESET;
            uart1_irq_route_q <= ROUTE_RESET;
            printer_irq_route_q <= ROUTE_RESET;
        end
        else
        begin
            // [R19] [R20] indirect writes
            if (wr_uart0)
            begin
                uart0_irq_route_q <= bus_i.wdata[3:0];
            end
            if (wr_uart1)
            begin
                uart1_irq_route_q <= bus_i.wdata[3:0];
            end
            if (wr_printer)
            begin
                printer_irq_route_q <= bus_i.wdata[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            data_q <= 8'h00;
            data_oe_n_q <= 1'b1;
            sel0_prev_q <= 1'b0;
        end
        else
        begin
            data_q <= data_d;
            data_oe_n_q <= data_oe_n_d;
            sel0_prev_q <= irq_mux_select_i[0];
        end
    end

    // outputs come from flops; mux outputs driven from reset
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            out_a_q <= 1'b0;
            out_a_oe_n_q <= 1'b0;
            out_b_q <= 1'b0;
            out_b_oe_n_q <= 1'b0;
            irq7_q <= 1'b0;
            irq7_oe_n_q <= 1'b1;
        end
        else
        begin
            out_a_q <= out_a_d;
            out_a_oe_n_q <= out_a_oe_n_d;
            out_b_q <= out_b_d;
            out_b_oe_n_q <= out_b_oe_n_d;
            irq7_q <= irq7_d;
            irq7_oe_n_q <= irq7_oe_n_d;
        end
    end

    assign data_o = data_q;
    assign data_oe_n_o = data_oe_n_q;
    assign mux_out_a_o = out_a_q;
    assign mux_out_a_oe_n_o = out_a_oe_n_q;
    assign mux_out_b_o = out_b_q;
    assign mux_out_b_oe_n_o = out_b_oe_n_q;
    assign irq7_o = irq7_q;
    assign irq7_oe_n_o = irq7_oe_n_q;

endmodule

`default_nettype wire

// >>> itmx_top_sva.sv
`timescale 1ns/100ps
`default_nettype none

module itmx_top_sva
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // inputs
    input wire logic [2:0] irq_mux_select_i,
    input wire itmx_pkg::itmx_irq_in_t irq_lines_i,
    input wire itmx_pkg::itmx_port_t ports_i,
    input wire itmx_pkg::itmx_bus_t bus_i,
    // outputs
    input wire logic [7:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic mux_out_a_o,
    input wire logic mux_out_a_oe_n_o,
    input wire logic mux_out_b_o,
    input wire logic mux_out_b_oe_n_o,
    input wire logic irq7_o,
    input wire logic irq7_oe_n_o
);
    import itmx_pkg::*;
    // ------------------------------------------------------------
    // shadow of the register file
    // ------------------------------------------------------------
    logic iow_q;
    logic [7:0] idx_q;
    logic [3:0] r0_q, r1_q, rp_q;
    wire wr_ok = !bus_i.cs2_n && !bus_i.iow_n && bus_i.ior_n && iow_q;
    wire rd_ok = !bus_i.cs2_n && !bus_i.ior_n && bus_i.iow_n;
    wire wr_dat = wr_ok && bus_i.addr == DATA_ACC_PORT;
    wire sa = r0_q == ROUTE_STANDALONE;
    wire plain = (r0_q | r1_q | rp_q) == ROUTE_OFF;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            iow_q <= 1'b1;
            idx_q <= ADDR_SEL_RESET;
            r0_q <= ROUTE_RESET;
            r1_q <= ROUTE_RESET;
            rp_q <= ROUTE_RESET;
        end
        else
        begin
            iow_q <= bus_i.iow_n;
            if (wr_ok && bus_i.addr == ADDR_SEL_PORT)
                idx_q <= bus_i.wdata;
            if (wr_dat && idx_q[2:0] == IDX_UART0_ROUTE)
                r0_q <= bus_i.wdata[3:0];
            if (wr_dat && idx_q[2:0] == IDX_UART1_ROUTE)
                r1_q <= bus_i.wdata[3:0];
            if (wr_dat && idx_q[2:0] == IDX_PRINTER_ROUTE)
                rp_q <= bus_i.wdata[3:0];
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_rom_pass: assert property (
        plain && irq_mux_select_i == 3'h4 |=> mux_out_a_o == $past(irq_lines_i.rom_size_in))
        else $error("rom size lane wrong");
    a_reset_pass: assert property (
        plain && irq_mux_select_i == 3'h5 |=> mux_out_a_o == $past(irq_lines_i.cpu_reset_request))
        else $error("cpu reset lane wrong");
    a_gate_pass: assert property (
        plain && irq_mux_select_i == 3'h2 |=> mux_out_b_o == $past(irq_lines_i.gate_a20_in))
        else $error("gate a20 lane wrong");
    a_irq8_high: assert property (
        plain && irq_mux_select_i == 3'h0 && (irq_lines_i.irq8 || $past(irq_lines_i.irq8))
        |=> mux_out_a_o) else $error("irq8 level not shown");
    a_irq9_low: assert property (
        plain && irq_mux_select_i == 3'h1 && !irq_lines_i.irq9 && !$past(irq_lines_i.irq9)
        |=> !mux_out_a_o) else $error("irq9 level not shown");
    a_solo_data: assert property (
        sa && !idx_q[TEST_BIT] |=> mux_out_a_o == $past(ports_i.uart0_irq)
        && mux_out_b_o == $past(ports_i.uart1_irq) && irq7_o == $past(ports_i.printer_irq))
        else $error("stand-alone data wrong");
    a_solo_enable: assert property (
        sa |=> mux_out_a_oe_n_o == !$past(ports_i.uart0_mcr[3])
        && irq7_oe_n_o == !$past(ports_i.printer_wcr[4])) else $error("stand-alone enable wrong");
    a_mux_driven: assert property (
        !sa |=> irq7_oe_n_o && !mux_out_a_oe_n_o && !mux_out_b_oe_n_o)
        else $error("pin enables wrong outside stand-alone");
    a_idx_read: assert property (
        rd_ok && bus_i.addr == ADDR_SEL_PORT |=> !data_oe_n_o && data_o == $past(idx_q))
        else $error("index read wrong");
    a_route_read: assert property (
        rd_ok && bus_i.addr == DATA_ACC_PORT && idx_q[2:0] == IDX_UART0_ROUTE
        |=> data_o == {4'h0, $past(r0_q)}) else $error("route read wrong");
    a_bus_quiet: assert property (
        bus_i.cs2_n |=> data_oe_n_o) else $error("bus driven while deselected");
    c_solo: cover property (sa && mux_out_a_o);
    c_read: cover property (rd_ok && bus_i.addr == ADDR_SEL_PORT);
    c_low: cover property (plain && irq_mux_select_i == 3'h1 && !irq_lines_i.irq9);
endmodule

bind itmx_top itmx_top_sva chk (.sys_clk_i, .nrst_i, .irq_mux_select_i, .irq_lines_i,
    .ports_i, .bus_i, .data_o, .data_oe_n_o, .mux_out_a_o, .mux_out_a_oe_n_o, .mux_out_b_o,
    .mux_out_b_oe_n_o, .irq7_o, .irq7_oe_n_o);

`default_nettype wire
